// ===== core/cpsi_pkg.sv
// constants for the card punch status and interrupt controller
// assumes one system clock; host channel signals are on that clock
package cpsi_pkg;
    // host function word (Q) fields
    localparam int Q_DIR0 = 0;
    localparam int Q_DIR1 = 1;
    localparam int Q_STN_LO = 5;
    localparam int Q_STN_HI = 6;
    localparam logic [1:0] STATION_CODE = 2'h2;
    localparam int Q_EQ_LO = 7;
    localparam int Q_EQ_HI = 10;
    localparam int Q_W_LO = 11;
    localparam int Q_W_HI = 15;
    // director function bits on the data bus
    localparam int D_CLR_CTL = 0;
    localparam int D_CLR_INT = 1;
    localparam int D_DATA_IRQ = 2;
    localparam int D_EOP_IRQ = 3;
    localparam int D_ALM_IRQ = 4;
    localparam int D_FEED = 7;
    localparam int D_OFFSET = 8;
    localparam int D_FUNC_LO = 2;
    localparam int D_FUNC_HI = 8;
    // controller status word bits
    localparam int S1_READY = 0;
    localparam int S1_BUSY = 1;
    localparam int S1_INT = 2;
    localparam int S1_DATA = 3;
    localparam int S1_EOP = 4;
    localparam int S1_ALARM = 5;
    localparam int S1_PROT = 7;
    localparam int S1_ERROR = 8;
    // punch device status word bits
    localparam int S2_HOPPER = 0;
    localparam int S2_PERR = 7;
    localparam int S2_OFFLINE = 8;
    localparam int S2_INHIBIT = 9;
    // sizes
    localparam int WORD_W = 16;
    localparam int COLUMN_W = 12;
    localparam int COL_CNT_W = 7;
    localparam int LAST_COLUMN = 80;
    // synchronised device input vector
    localparam int IN_READY = 0;
    localparam int IN_OFFLINE = 1;
    localparam int IN_INHIBIT = 2;
    localparam int IN_HOPPER = 3;
    localparam int IN_PERR = 4;
    localparam int IN_COLACK = 5;
    localparam int IN_FEEDACK = 6;
    localparam int IN_PROT = 7;
    localparam int IN_EQ_LO = 8;
    localparam int IN_W = 12;
    // reset values
    localparam logic RST_DATA_FLAG = 1'b1;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int BUSY_DROP_NS = 100;
    localparam int BUSY_DROP_CYC = BUSY_DROP_NS * CLK_MHZ / 1000;
    localparam int INT_SET_NS = 100;
    localparam int INT_SET_CYC = INT_SET_NS * CLK_MHZ / 1000;
    // column transfer states
    typedef enum logic [1:0] {
        XF_IDLE = 2'b01,
        XF_WAIT = 2'b10
    } cpsi_xfer_t;
endpackage

// ===== core/cpsi_dec_if.sv
// decode bundle between the controller and its instruction checker
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface cpsi_dec_if;
    logic readStb;
    logic writeStb;
    logic protectedInstr;
    logic [15:0] func;
    logic [15:0] busIn;
    logic [3:0] equipJumper;
    logic protectOn;
    logic ready;
    logic inhibit;
    logic dataStatus;
    logic isData;
    logic isDir;
    logic isStat1;
    logic isStat2;
    logic accept;
    logic extReject;
    logic intReject;
    modport dec (
        input readStb, writeStb, protectedInstr, func, busIn,
        input equipJumper, protectOn, ready, inhibit, dataStatus,
        output isData, isDir, isStat1, isStat2,
        output accept, extReject, intReject
    );
    modport ctl (
        output readStb, writeStb, protectedInstr, func, busIn,
        output equipJumper, protectOn, ready, inhibit, dataStatus,
        input isData, isDir, isStat1, isStat2,
        input accept, extReject, intReject
    );
endinterface

// ===== core/cpsi_decode.sv
// instruction checker: addressing, operation decode, reject decision
// assumes strobes are single-cycle pulses on the system clock
`timescale 1ns/1ns
module cpsi_decode (
    cpsi_dec_if.dec d
);
    wire strobe = d.readStb | d.writeStb;
    wire dir0 = d.func[cpsi_pkg::Q_DIR0];
    wire dir1 = d.func[cpsi_pkg::Q_DIR1];
    wire eqMiss = d.func[cpsi_pkg::Q_EQ_HI:cpsi_pkg::Q_EQ_LO] !=
        d.equipJumper;
    wire stnMiss = d.func[cpsi_pkg::Q_STN_HI:cpsi_pkg::Q_STN_LO] !=
        cpsi_pkg::STATION_CODE;
    wire wNonzero = |d.func[cpsi_pkg::Q_W_HI:cpsi_pkg::Q_W_LO];
    wire otherFuncs =
        |d.busIn[cpsi_pkg::D_FUNC_HI:cpsi_pkg::D_FUNC_LO];
    wire wrData = d.writeStb & ~dir1 & ~dir0;
    wire wrDir = d.writeStb & ~dir1 & dir0;
    wire feedBit = d.busIn[cpsi_pkg::D_FEED];

    wire badRead = d.readStb & ~dir0;
    wire badWrite = d.writeStb & dir1;
    wire protViol = d.writeStb & d.protectOn & ~d.protectedInstr;
    wire dataNotReady = wrData & ~d.dataStatus;
    wire dataInhibit = wrData & d.inhibit;
    wire dirNotReady = wrDir & ~d.ready & otherFuncs;
    wire feedInhibit = wrDir & feedBit & d.inhibit;

    assign d.intReject = strobe & (eqMiss | stnMiss | wNonzero);
    assign d.extReject = strobe & ~d.intReject &
        (badRead | badWrite | protViol | dataNotReady |
         dataInhibit | dirNotReady | feedInhibit);
    assign d.accept = strobe & ~d.intReject & ~d.extReject;
    assign d.isData = wrData;
    assign d.isDir = wrDir;
    assign d.isStat1 = d.readStb & dir0 & ~dir1;
    assign d.isStat2 = d.readStb & dir0 & dir1;
endmodule // cpsi_decode

// ===== core/cpsi_card_punch_ctl.sv
// card punch controller: status words, rejects and interrupt responses
// assumes host strobes and master clear share the system clock;
// punch lines and jumpers are asynchronous and are synchronised here
//
// Overview of operation
// - Busy drops in the same cycle the card done flag sets.
// - Interrupt status bit rises with the response, one cycle after cause.
// - Controller clear and master clear force data-ready set.
// - Data-ready clears on data write, feed, not ready, inhibit.
// - After column 80 data-ready stays clear until a new feed.
// - Card done sets at column 80 end, not for cards cut short.
// - Not ready during card processing sets card done and alarm.
// - Card done clears on feed, controller clear, master clear.
// - Alarm sets on not ready or inhibit in card, or on any punch error.
// - Error sets on punch echo error; feed or clears reset it.
// - Both director bits high on read returns the device status word.
// - Device word: hopper empty, punch error, offline, inhibit bits.
// - Punch inhibit rejects punch data writes and feed requests.
// - External reject for illegal codes, protect, not ready cases.
// - Internal reject, no answer, on address or width mismatch.
// - Three separate responses; clears drop all responses and every request not set in the same word.
// - Data response is request and data-ready, dropped on transfer.
// - Card done response only for an end after its request.
// - Alarm response while alarm exists with its request set.
// - Common response is the OR of the three responses.
// - Equipment number in function bits 7-10 must match jumpers.
// - Protect jumper shows in status; unprotected writes rejected.
// - Director bit 0 high, bit 1 low reads the controller status.
// - Punch data write carries twelve column bits on lines 0-11.
`timescale 1ns/1ns
module cpsi_card_punch_ctl (
    // system
    input wire logic clock,
    input wire logic rst,
    // host channel
    input wire logic host_master_clear,
    input wire logic readStb,
    input wire logic writeStb,
    input wire logic protectedInstr,
    input wire logic [15:0] func,
    input wire logic [15:0] busIn,
    output logic [15:0] busOut,
    output logic busOe,
    output logic reply,
    output logic extReject,
    // punch mechanism
    input wire logic punchReadyPin,
    input wire logic punchOfflinePin,
    input wire logic punchInhibitPin,
    input wire logic hopperEmptyPin,
    input wire logic punchErrorPin,
    input wire logic columnAckPin,
    input wire logic feedAckPin,
    output logic [11:0] punchColumn,
    output logic punchStrobe,
    output logic feedCmd,
    output logic offsetCmd,
    // board jumpers
    input wire logic [3:0] equipJumper,
    input wire logic protect_jumper,
    // interrupt responses
    output logic dataIntResp,
    output logic eopIntResp,
    output logic alarmIntResp,
    output logic commonIntResp
);
    localparam int NI = cpsi_pkg::IN_W;

    // three-stage input synchronisers with agreement filter
    logic [NI-1:0] sync1;
    logic [NI-1:0] sync2;
    logic [NI-1:0] sync3;
    logic [NI-1:0] filt;
    logic [NI-1:0] filtPrev;
    wire [NI-1:0] rawIn = {equipJumper, protect_jumper, feedAckPin,
        columnAckPin, punchErrorPin, hopperEmptyPin, punchInhibitPin,
        punchOfflinePin, punchReadyPin};

    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    filt[gi] <= 1'b0;
                    filtPrev[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= rawIn[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        filt[gi] <= sync3[gi];
                    end
                    filtPrev[gi] <= filt[gi];
                end
            end
        end
    endgenerate

    // device conditions
    wire punchRdy = filt[cpsi_pkg::IN_READY];
    wire punch_offline_flag = filt[cpsi_pkg::IN_OFFLINE];
    wire inhibit = filt[cpsi_pkg::IN_INHIBIT];
    wire hopperEmpty = filt[cpsi_pkg::IN_HOPPER];
    wire punchErr = filt[cpsi_pkg::IN_PERR];
    wire protectOn = filt[cpsi_pkg::IN_PROT];
    wire [3:0] equipSet = filt[cpsi_pkg::IN_EQ_LO +: 4];
    wire ready = punchRdy & ~punch_offline_flag;
    wire [NI-1:0] rise = filt & ~filtPrev;
    wire perrRise = rise[cpsi_pkg::IN_PERR];
    wire colAckRise = rise[cpsi_pkg::IN_COLACK];
    wire feedAckRise = rise[cpsi_pkg::IN_FEEDACK];

    // flags
    cpsi_pkg::cpsi_xfer_t xferState;
    logic [cpsi_pkg::COL_CNT_W-1:0] colCount;
    logic busy;
    logic inCard;
    logic cutShort;
    logic dataFlag;
    logic card_done_flag;
    logic alarm;
    logic errorFlag;
    logic dataReq;
    logic eopReq;
    logic alarmReq;
    wire dataStatus = dataFlag & ready & ~inhibit;

    // instruction checker
    cpsi_dec_if dif ();
    assign dif.readStb = readStb;
    assign dif.writeStb = writeStb;
    assign dif.protectedInstr = protectedInstr;
    assign dif.func = func;
    assign dif.busIn = busIn;
    assign dif.equipJumper = equipSet;
    assign dif.protectOn = protectOn;
    assign dif.ready = ready;
    assign dif.inhibit = inhibit;
    assign dif.dataStatus = dataStatus;

    cpsi_decode u_decode (
        .d(dif.dec)
    );

    // accepted operations
    wire dirWr = dif.accept & dif.isDir;
    wire dataWr = dif.accept & dif.isData;
    wire clrCtl = dirWr & busIn[cpsi_pkg::D_CLR_CTL];
    wire clrInt = dirWr & busIn[cpsi_pkg::D_CLR_INT];
    wire feedReq = dirWr & busIn[cpsi_pkg::D_FEED];
    wire offReq = dirWr & busIn[cpsi_pkg::D_OFFSET];
    wire clrAll = clrCtl | host_master_clear;
    wire clrIrq = clrAll | clrInt;

    // column transfer events
    wire xferIdle = xferState == cpsi_pkg::XF_IDLE;
    wire colDone = ~xferIdle & colAckRise;
    wire lastCol = colDone &
        (colCount == cpsi_pkg::COL_CNT_W'(cpsi_pkg::LAST_COLUMN - 1));
    wire notReadyEvt = inCard & (~ready | inhibit);
    wire eopSet = (lastCol & ~cutShort) | notReadyEvt;

    always_ff @(posedge clock) begin
        if (rst || clrAll) begin
            xferState <= cpsi_pkg::XF_IDLE;
            punchStrobe <= 1'b0;
            punchColumn <= '0;
        end else if (xferIdle && dataWr) begin
            xferState <= cpsi_pkg::XF_WAIT;
            punchStrobe <= 1'b1;
            punchColumn <= busIn[cpsi_pkg::COLUMN_W-1:0];
        end else if (colDone) begin
            xferState <= cpsi_pkg::XF_IDLE;
            punchStrobe <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || clrAll || feedReq) begin
            colCount <= '0;
        end else if (colDone && !cutShort) begin
            colCount <= colCount + 1'b1;
        end
    end

    // card window, busy and cut-short tracking
    always_ff @(posedge clock) begin
        if (rst || clrAll) begin
            inCard <= 1'b0;
            cutShort <= 1'b0;
        end else begin
            if (feedReq) begin
                inCard <= 1'b1;
            end else if (lastCol || notReadyEvt) begin
                inCard <= 1'b0;
            end
            if (feedReq && busy) begin
                cutShort <= 1'b1;
            end else if (colDone) begin
                cutShort <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst || clrAll || !ready) begin
            busy <= 1'b0;
        end else if (eopSet || (colDone && cutShort)) begin
            busy <= 1'b0;
        end else if (dataWr) begin
            busy <= 1'b1;
        end
    end

    // data-ready
    always_ff @(posedge clock) begin
        if (rst || clrAll) begin
            dataFlag <= cpsi_pkg::RST_DATA_FLAG;
        end else if (feedAckRise) begin
            dataFlag <= 1'b1;
        end else if (feedReq || dataWr) begin
            dataFlag <= 1'b0;
        end else if (colDone && !lastCol && !cutShort) begin
            dataFlag <= 1'b1;
        end
    end

    // card done, alarm and error flags; set wins over feed clear
    always_ff @(posedge clock) begin
        if (rst) begin
            card_done_flag <= 1'b0;
            alarm <= 1'b0;
            errorFlag <= 1'b0;
        end else begin
            if (eopSet) begin
                card_done_flag <= 1'b1;
            end else if (feedReq || clrAll) begin
                card_done_flag <= 1'b0;
            end
            if (notReadyEvt || perrRise) begin
                alarm <= 1'b1;
            end else if (feedReq || clrAll) begin
                alarm <= 1'b0;
            end
            if (perrRise) begin
                errorFlag <= 1'b1;
            end else if (feedReq || clrAll) begin
                errorFlag <= 1'b0;
            end
        end
    end

    // feed and offset motion requests
    always_ff @(posedge clock) begin
        if (rst || clrAll) begin
            feedCmd <= 1'b0;
            offsetCmd <= 1'b0;
        end else begin
            if (feedReq) begin
                feedCmd <= 1'b1;
            end else if (feedAckRise) begin
                feedCmd <= 1'b0;
            end
            if (offReq) begin
                offsetCmd <= 1'b1;
            end else if (feedAckRise) begin
                offsetCmd <= 1'b0;
            end
        end
    end

    // interrupt requests; a request in the same word beats the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            dataReq <= 1'b0;
            eopReq <= 1'b0;
            alarmReq <= 1'b0;
        end else begin
            if (dirWr && busIn[cpsi_pkg::D_DATA_IRQ]) begin
                dataReq <= 1'b1;
            end else if (clrIrq) begin
                dataReq <= 1'b0;
            end
            if (dirWr && busIn[cpsi_pkg::D_EOP_IRQ]) begin
                eopReq <= 1'b1;
            end else if (clrIrq) begin
                eopReq <= 1'b0;
            end
            if (dirWr && busIn[cpsi_pkg::D_ALM_IRQ]) begin
                alarmReq <= 1'b1;
            end else if (clrIrq) begin
                alarmReq <= 1'b0;
            end
        end
    end

    // interrupt responses
    wire respKill = clrIrq | feedReq;
    wire next_dataResp = dataReq & dataStatus & ~respKill & ~dataWr;
    wire next_eopResp = ~respKill &
        (eopIntResp | (eopSet & eopReq));
    wire next_alarmResp = alarmReq & alarm & ~respKill;

    always_ff @(posedge clock) begin
        if (rst) begin
            dataIntResp <= 1'b0;
            eopIntResp <= 1'b0;
            alarmIntResp <= 1'b0;
            commonIntResp <= 1'b0;
        end else begin
            dataIntResp <= next_dataResp;
            eopIntResp <= next_eopResp;
            alarmIntResp <= next_alarmResp;
            commonIntResp <= next_dataResp | next_eopResp |
                next_alarmResp;
        end
    end

    // status words, sampled when the read is taken
    wire [15:0] stat1 = 16'(
        (ready << cpsi_pkg::S1_READY) |
        (busy << cpsi_pkg::S1_BUSY) |
        (commonIntResp << cpsi_pkg::S1_INT) |
        (dataStatus << cpsi_pkg::S1_DATA) |
        (card_done_flag << cpsi_pkg::S1_EOP) |
        (alarm << cpsi_pkg::S1_ALARM) |
        (protectOn << cpsi_pkg::S1_PROT) |
        (errorFlag << cpsi_pkg::S1_ERROR));
    wire [15:0] stat2 = 16'(
        (hopperEmpty << cpsi_pkg::S2_HOPPER) |
        (punchErr << cpsi_pkg::S2_PERR) |
        (punch_offline_flag << cpsi_pkg::S2_OFFLINE) |
        (inhibit << cpsi_pkg::S2_INHIBIT));
    wire statRead = dif.accept & (dif.isStat1 | dif.isStat2);
    wire [15:0] readWord = dif.isStat2 ? stat2 : stat1;

    always_ff @(posedge clock) begin
        if (rst) begin
            busOut <= '0;
            busOe <= 1'b0;
            reply <= 1'b0;
            extReject <= 1'b0;
        end else begin
            busOut <= statRead ? readWord : 16'h0000;
            busOe <= statRead;
            reply <= dif.accept;
            extReject <= dif.extReject;
        end
    end
endmodule // cpsi_card_punch_ctl

// ===== verification/cpsi_ctl_monitor.sv
// assertions on the card punch controller top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module cpsi_ctl_monitor (
    // system
    input wire logic clock,
    input wire logic rst,
    // host channel
    input wire logic host_master_clear,
    input wire logic readStb,
    input wire logic writeStb,
    input wire logic [15:0] func,
    input wire logic [15:0] busIn,
    input wire logic busOe,
    input wire logic reply,
    input wire logic extReject,
    // punch
    input wire logic [11:0] punchColumn,
    input wire logic punchStrobe,
    // interrupt responses
    input wire logic dataIntResp,
    input wire logic eopIntResp,
    input wire logic alarmIntResp,
    input wire logic commonIntResp
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire logic anyStb = readStb | writeStb;

    a_common_or: assert property (commonIntResp ==
        (dataIntResp | eopIntResp | alarmIntResp))
        else $error("common response differs from OR");
    a_idle_silent: assert property (!anyStb |=> !reply && !extReject)
        else $error("answer without strobe");
    a_one_answer: assert property (reply |-> !extReject)
        else $error("reply and reject together");
    a_read_dir: assert property (readStb && !func[0] |=> !reply)
        else $error("read with low director bit accepted");
    a_write_dir: assert property (writeStb && func[1] |=> !reply)
        else $error("write with high director bit accepted");
    a_width_quiet: assert property (anyStb && func[15:11] != 5'h00
        |=> !reply && !extReject)
        else $error("nonzero width field answered");
    a_station_quiet: assert property (anyStb
        && func[6:5] != cpsi_pkg::STATION_CODE
        |=> !reply && !extReject)
        else $error("wrong station code answered");
    a_oe_reply: assert property (busOe |-> reply)
        else $error("bus driven without reply");
    a_column_out: assert property (writeStb && func[1:0] == 2'h0 ##1 reply
        |-> punchStrobe && punchColumn == $past(busIn[11:0]))
        else $error("column word not passed to punch");
    a_clear_resp: assert property (host_master_clear
        |=> !dataIntResp && !eopIntResp && !alarmIntResp)
        else $error("master clear left a response");
endmodule // cpsi_ctl_monitor

bind cpsi_card_punch_ctl cpsi_ctl_monitor mon (.clock(clock), .rst(rst),
    .host_master_clear(host_master_clear), .readStb(readStb),
    .writeStb(writeStb), .func(func), .busIn(busIn), .busOe(busOe),
    .reply(reply), .extReject(extReject), .punchColumn(punchColumn),
    .punchStrobe(punchStrobe), .dataIntResp(dataIntResp),
    .eopIntResp(eopIntResp), .alarmIntResp(alarmIntResp),
    .commonIntResp(commonIntResp));

// ===== verification/cpsi_punch_model.sv
// card punch mechanism model: acknowledges columns and feeds
// assumes command levels from the controller on the system clock
`timescale 1ns/1ns
module cpsi_punch_model (
    // system
    input wire logic clock,
    // controller commands
    input wire logic punchStrobe,
    input wire logic feedCmd,
    input wire logic slow,
    // acknowledges
    output logic columnAckPin,
    output logic feedAckPin
);
    logic isFeed;
    initial begin
        columnAckPin = 1'b0;
        feedAckPin = 1'b0;
        forever begin
            @(posedge clock);
            if (punchStrobe || feedCmd) begin
                // a pending column is punched before the feed moves the card
                isFeed = !punchStrobe;
                repeat (slow ? 12 : 2) @(posedge clock);
                if (isFeed)
                    feedAckPin <= 1'b1;
                else
                    columnAckPin <= 1'b1;
                // held past the input filter, then a gap for the next edge
                repeat (4) @(posedge clock);
                feedAckPin <= 1'b0;
                columnAckPin <= 1'b0;
                repeat (4) @(posedge clock);
            end
        end
    end
endmodule // cpsi_punch_model

// ===== verification/tb_top.sv
// self-checking bench for the card punch controller
// assumes the punch model answers commands; host driven here
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
    begin \
        testsRun++; \
        if ((gt) !== (ex)) begin \
            fails++; \
            $display("unexpected %s: expected %h seen %h", nm, ex, gt); \
        end \
    end
module tb_top;
    localparam logic [15:0] FB = 16'h02c0;
    typedef struct packed {
        logic w; logic [15:0] f; logic [15:0] d;
        logic rep; logic rej; logic [15:0] dat;
    } cpsi_row_t;
    cpsi_row_t rows [10] = '{
        '{1'b0, 16'h02c1, 16'h0, 1'b1, 1'b0, 16'h0009},
        '{1'b0, 16'h02c3, 16'h0, 1'b1, 1'b0, 16'h0000},
        '{1'b0, 16'h02c0, 16'h0, 1'b0, 1'b1, 16'h0},
        '{1'b0, 16'h02c2, 16'h0, 1'b0, 1'b1, 16'h0},
        '{1'b1, 16'h02c2, 16'h0, 1'b0, 1'b1, 16'h0},
        '{1'b1, 16'h02c3, 16'h0, 1'b0, 1'b1, 16'h0},
        '{1'b0, 16'h0341, 16'h0, 1'b0, 1'b0, 16'h0},
        '{1'b0, 16'h0281, 16'h0, 1'b0, 1'b0, 16'h0},
        '{1'b0, 16'h0ac1, 16'h0, 1'b0, 1'b0, 16'h0},
        '{1'b1, 16'h02c1, 16'h2, 1'b1, 1'b0, 16'h0}};
    logic clock, rst, hmc, rdS, wrS, prot, busOe, reply, extReject;
    logic [15:0] func, busIn, busOut, gotDat;
    logic readyPin, offPin, inhPin, hopPin, errPin, colAck, feedAck;
    logic [11:0] punchColumn;
    logic punchStrobe, feedCmd, protJ, slow, gotRep, gotRej, offCmd;
    logic dataResp, eopResp, alarmResp, commonResp;
    int fails = 0;
    int testsRun = 0;

    cpsi_card_punch_ctl dut (.clock(clock), .rst(rst),
        .host_master_clear(hmc), .readStb(rdS), .writeStb(wrS),
        .protectedInstr(prot), .func(func), .busIn(busIn),
        .busOut(busOut), .busOe(busOe), .reply(reply),
        .extReject(extReject), .punchReadyPin(readyPin),
        .punchOfflinePin(offPin), .punchInhibitPin(inhPin),
        .hopperEmptyPin(hopPin), .punchErrorPin(errPin),
        .columnAckPin(colAck), .feedAckPin(feedAck),
        .punchColumn(punchColumn), .punchStrobe(punchStrobe),
        .feedCmd(feedCmd), .offsetCmd(offCmd), .equipJumper(4'h5),
        .protect_jumper(protJ), .dataIntResp(dataResp),
        .eopIntResp(eopResp), .alarmIntResp(alarmResp),
        .commonIntResp(commonResp));
    cpsi_punch_model punch (.clock(clock), .punchStrobe(punchStrobe),
        .feedCmd(feedCmd), .slow(slow), .columnAckPin(colAck),
        .feedAckPin(feedAck));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic finishTest;
        $display("checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmd(input logic w, input logic [15:0] f,
                       input logic [15:0] d);
        @(posedge clock);
        rdS <= !w;
        wrS <= w;
        func <= f;
        busIn <= d;
        @(posedge clock);
        rdS <= 1'b0;
        wrS <= 1'b0;
        @(negedge clock);
        gotRep = reply;
        gotRej = extReject;
        gotDat = busOut;
    endtask

    // polls status until data may be sent
    task automatic waitData;
        for (int i = 0; i < 60; i++) begin
            cmd(1'b0, FB | 16'h1, 16'h0);
            if (gotDat[3] === 1'b1)
                return;
        end
        fails++;
        finishTest;
    endtask

    task automatic waitIdle;
        for (int i = 0; i < 60; i++) begin
            @(negedge clock);
            if (punchStrobe === 1'b0 && feedCmd === 1'b0)
                return;
        end
        fails++;
        finishTest;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        finishTest;
    end

    initial begin
        {rst, hmc, rdS, wrS, prot, protJ, slow} = 7'h40;
        {readyPin, offPin, inhPin, hopPin, errPin} = 5'h10;
        func = 16'h0;
        busIn = 16'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        foreach (rows[i]) begin
            cmd(rows[i].w, rows[i].f, rows[i].d);
            `CHK("reply", rows[i].rep, gotRep)
            `CHK("reject", rows[i].rej, gotRej)
            if (rows[i].rep && !rows[i].w)
                `CHK("status", rows[i].dat, gotDat)
        end
        $display("test table done");
        {offPin, inhPin, hopPin} <= 3'h7;
        repeat (6) @(posedge clock);
        cmd(1'b0, FB | 16'h3, 16'h0);
        `CHK("device word", 16'h0301, gotDat)
        cmd(1'b1, FB | 16'h1, 16'h0080);
        `CHK("feed inhibited", 1'b1, gotRej)
        cmd(1'b1, FB, 16'h0123);
        `CHK("data inhibited", 1'b1, gotRej)
        {offPin, inhPin, hopPin} <= 3'h0;
        repeat (6) @(posedge clock);
        $display("test device word done");
        cmd(1'b1, FB | 16'h1, 16'h0088);
        waitData;
        for (int c = 1; c <= 80; c++) begin
            slow <= c[0];
            cmd(1'b1, FB, 16'(c));
            `CHK("column reply", 1'b1, gotRep)
            if (c == 1) begin
                cmd(1'b1, FB, 16'h0);
                `CHK("early data", 1'b1, gotRej)
            end
            if (c < 80)
                waitData;
        end
        waitIdle;
        cmd(1'b0, FB | 16'h1, 16'h0);
        `CHK("card end", 16'h0015, gotDat)
        `CHK("card end response", 1'b1, eopResp)
        `CHK("common response", 1'b1, commonResp)
        cmd(1'b1, FB, 16'h0);
        `CHK("data after card", 1'b1, gotRej)
        $display("test full card done");
        cmd(1'b1, FB | 16'h1, 16'h0080);
        waitData;
        `CHK("feed clears card end", 1'b0, gotDat[4])
        `CHK("feed clears response", 1'b0, eopResp)
        cmd(1'b1, FB, 16'h0fff);
        cmd(1'b1, FB | 16'h1, 16'h0180);
        `CHK("offset", 1'b1, offCmd)
        waitIdle;
        waitData;
        `CHK("cut short", 16'h0009, gotDat)
        $display("test cut short done");
        cmd(1'b1, FB | 16'h1, 16'h0010);
        readyPin <= 1'b0;
        repeat (6) @(posedge clock);
        readyPin <= 1'b1;
        errPin <= 1'b1;
        repeat (6) @(posedge clock);
        cmd(1'b0, FB | 16'h1, 16'h0);
        `CHK("alarm status", 16'h0130, gotDat & 16'h0130)
        `CHK("alarm response", 1'b1, alarmResp)
        errPin <= 1'b0;
        cmd(1'b1, FB | 16'h1, 16'h0001);
        cmd(1'b0, FB | 16'h1, 16'h0);
        `CHK("cleared status", 16'h0009, gotDat)
        `CHK("cleared response", 1'b0, commonResp)
        $display("test alarm done");
        cmd(1'b1, FB | 16'h1, 16'h0004);
        cmd(1'b0, FB | 16'h1, 16'h0);
        `CHK("data response", 1'b1, dataResp)
        `CHK("interrupt status", 16'h000d, gotDat)
        hmc <= 1'b1;
        @(posedge clock);
        hmc <= 1'b0;
        cmd(1'b0, FB | 16'h1, 16'h0);
        `CHK("master clear", 16'h0009, gotDat)
        protJ <= 1'b1;
        repeat (6) @(posedge clock);
        cmd(1'b0, FB | 16'h1, 16'h0);
        `CHK("protect status", 16'h0089, gotDat)
        cmd(1'b1, FB | 16'h1, 16'h0002);
        `CHK("unprotected write", 1'b1, gotRej)
        prot <= 1'b1;
        cmd(1'b1, FB | 16'h1, 16'h0002);
        `CHK("protected write", 1'b1, gotRep)
        $display("test interrupts and protect done");
        finishTest;
    end
endmodule // tb_top
